/* File: dis_dram_dev.sv */
// Device end: bus state tracker, mode registers and burst engine of the DRAM
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Activate picks row; read/write picks column
// - One core word moves as eight beats
// - Bursts start at column, programmed length, order
// - Self refresh allows power-down and mode commands
// - Idle reported only with every bank closed
// - Training stays until controller exits it
// - Auto-return states go back where entered
// - Reset pin low forces reset state always
// - Latency, recovery and set-point defaults after reset
// - Bus inversion and termination disabled after reset
// - Reference ranges one, values 001101 after reset
// - Controller ramps all channels together
// - Outputs undriven while reset pin low
// - Controller holds reset for ramp hold
// - Clock enable low before reset release
// - Wait delay and stable clock before enable
// - Chip select low when enable first rises
// - Idle wait before first mode command
// - Boot clock range, relaxed output timing
// - Ramp reset hold at least 200 us
// - Reset release to enable at least 2 ms
// - Five stable clocks before enable rises
// - At least 2 us before first mode command
////////////////////////////////////////////////////////////////////////////////
module dis_dram_dev
  import dis_pkg::*;
#(
  parameter int unsigned DQ_W   = 16,
  parameter int unsigned MEM_AW = 8
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  dis_link_if.dev                   lnk,
  output dis_dev_state_t            state_o,
  output logic                      idle_o,
  output logic [7:0]                open_banks_o
);
  localparam int unsigned BEAT_W = 2 * DQ_W;
  localparam int unsigned WORD_W = BEATS_PER_WORD * BEAT_W;
  localparam int unsigned IN_W   = 3 + 4 + 3 + 14 + 8 + BEAT_W;

  if (DQ_W == 0 || MEM_AW == 0 || MEM_AW > 16)
    $error("dis_dram_dev: unsupported parameter values");

  function automatic logic [7:0] mr_default(input logic [5:0] a);
    case (a)
      MR1_ADDR:  return MR1_RST;
      MR2_ADDR:  return MR2_RST;
      MR3_ADDR:  return MR3_RST;
      MR11_ADDR: return MR11_RST;
      MR12_ADDR: return MR12_RST;
      MR13_ADDR: return MR13_RST;
      MR14_ADDR: return MR14_RST;
      default:   return 8'h00;
    endcase
  endfunction

  function automatic logic [MEM_AW-1:0] mem_idx(input logic [2:0] b, input logic [13:0] r,
                                                input logic [5:0] c);
    return MEM_AW'({r, b, c});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  logic [IN_W-1:0]   sync1_q;
  logic [IN_W-1:0]   sync2_q;
  logic              p_reset_n, p_cke, p_cs;
  logic [3:0]        p_cmd;
  logic [2:0]        p_ba;
  logic [13:0]       p_addr;
  logic [7:0]        p_op;
  logic [BEAT_W-1:0] p_dq;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clk_en)
    begin
      sync1_q <= {lnk.reset_n, lnk.cke, lnk.cs, lnk.cmd, lnk.ba, lnk.addr, lnk.op, lnk.dq};
      sync2_q <= sync1_q;
    end
  end
  assign {p_reset_n, p_cke, p_cs, p_cmd, p_ba, p_addr, p_op, p_dq} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // State tracker and burst engine
  dis_dev_state_t    state_q, state_d, ret_q, ret_d;
  logic [7:0]        open_q, open_d;
  logic [13:0]       row_q [8];
  logic [13:0]       row_d [8];
  logic [2:0]        bank_q, bank_d;
  logic [5:0]        wcol_q, wcol_d, wcol_nxt;
  logic              last_q, last_d, idle_q, idle_d, oe_q, oe_d, allow_mode;
  logic [2:0]        beat_q, beat_d;
  logic [WORD_W-1:0] rword_q, rword_d, wbuf_q, wbuf_d;
  logic [BEAT_W-1:0] dq_q, dq_d;
  logic [7:0]        mr_q [64];
  logic [7:0]        mr_d [64];
  logic [WORD_W-1:0] mem_q [2**MEM_AW];
  logic              mem_we;
  logic [MEM_AW-1:0] mem_wa;

  always_comb
  begin
    state_d = state_q;
    ret_d = ret_q;
    open_d = open_q;
    row_d = row_q;
    bank_d = bank_q;
    wcol_d = wcol_q;
    last_d = last_q;
    beat_d = beat_q;
    rword_d = rword_q;
    wbuf_d = wbuf_q;
    dq_d = '0;
    oe_d = 1'b0;
    mr_d = mr_q;
    mem_we = 1'b0;
    mem_wa = mem_idx(bank_q, row_q[bank_q], wcol_q);
    allow_mode = 1'b0;
    wcol_nxt = mr_q[MR1_ADDR][MR1_ORDER_BIT] ? (wcol_q ^ 6'h01) : (wcol_q + 6'h01);
    case (state_q)
      DS_RESET: if (p_reset_n) state_d = DS_INIT;
      DS_INIT: if (p_cke) state_d = DS_IDLE;
      DS_IDLE, DS_ACTIVE:
        if (!p_cke)
        begin
          ret_d = state_q;
          state_d = DS_PDN;
        end
        else
        begin
          allow_mode = 1'b1;
          if (p_cs)
            case (p_cmd)
              CMD_ACT:
              begin
                open_d[p_ba] = 1'b1;
                row_d[p_ba] = p_addr;
                state_d = DS_ACTIVE;
              end
              CMD_PRE:
              begin
                if (p_op[PRE_ALL_BIT])
                  open_d = '0;
                else
                  open_d[p_ba] = 1'b0;
                state_d = (open_d == '0) ? DS_IDLE : DS_ACTIVE;
              end
              CMD_RD, CMD_WR:
                if (open_q[p_ba])
                begin
                  bank_d = p_ba;
                  wcol_d = p_addr[COL_WORD_LSB +: 6];
                  last_d = !mr_q[MR1_ADDR][MR1_BL_BIT];
                  beat_d = '0;
                  rword_d = mem_q[mem_idx(p_ba, row_q[p_ba], p_addr[COL_WORD_LSB +: 6])];
                  state_d = (p_cmd == CMD_RD) ? DS_READ : DS_WRITE;
                end
              CMD_SRE: if (state_q == DS_IDLE) state_d = DS_SREF;
              default: ;
            endcase
        end
      DS_SREF:
      begin
        allow_mode = p_cke;
        if (!p_cke)
        begin
          ret_d = DS_SREF;
          state_d = DS_PDN;
        end
        else if (p_cs && p_cmd == CMD_SRX)
          state_d = DS_IDLE;
      end
      DS_PDN: if (p_cke) state_d = ret_q;
      DS_MRR, DS_MRW, DS_MPC: state_d = ret_q;
      DS_TRAIN:
        if (p_cs && p_cmd == CMD_MPC && p_op == MPC_TRAIN_EXIT)
          state_d = ret_q;
        else if (p_cs && p_cmd == CMD_MRW)
        begin
          mr_d[p_addr[5:0]] = p_op;
          if (p_addr[5:0] == MR13_ADDR && !p_op[MR13_TRAIN_BIT])
            state_d = ret_q;
        end
      DS_READ:
      begin
        oe_d = 1'b1;
        dq_d = rword_q[beat_q*BEAT_W +: BEAT_W];
        beat_d = beat_q + 3'h1;
        if (beat_q == 3'h7)
        begin
          if (last_q)
            state_d = DS_ACTIVE;
          else
          begin
            last_d = 1'b1;
            wcol_d = wcol_nxt;
            rword_d = mem_q[mem_idx(bank_q, row_q[bank_q], wcol_nxt)];
          end
        end
      end
      DS_WRITE:
      begin
        wbuf_d = {p_dq, wbuf_q[WORD_W-1:BEAT_W]};
        beat_d = beat_q + 3'h1;
        if (beat_q == 3'h7)
        begin
          mem_we = 1'b1;
          if (last_q)
            state_d = DS_ACTIVE;
          else
          begin
            last_d = 1'b1;
            wcol_d = wcol_nxt;
          end
        end
      end
      default: state_d = DS_RESET;
    endcase
    if (allow_mode && p_cs)
      case (p_cmd)
        CMD_MRW:
        begin
          mr_d[p_addr[5:0]] = p_op;
          ret_d = state_q;
          state_d = (p_addr[5:0] == MR13_ADDR && p_op[MR13_TRAIN_BIT]) ? DS_TRAIN : DS_MRW;
        end
        CMD_MRR:
        begin
          oe_d = 1'b1;
          dq_d = BEAT_W'(mr_q[p_addr[5:0]]);
          ret_d = state_q;
          state_d = DS_MRR;
        end
        CMD_MPC:
        begin
          ret_d = state_q;
          state_d = (p_op == MPC_TRAIN_START) ? DS_TRAIN : DS_MPC;
        end
        default: ;
      endcase
    // Reset pin overrides state, open banks and output enable (not a core write) and reloads the defaults
    if (!p_reset_n)
    begin
      state_d = DS_RESET;
      open_d = '0;
      oe_d = 1'b0;
      for (int i = 0; i < 64; i++)
        mr_d[i] = mr_default(6'(i));
    end
    idle_d = (state_d == DS_IDLE) && (open_d == '0);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= DS_RESET;
      ret_q <= DS_IDLE;
      open_q <= '0;
      row_q <= '{default: '0};
      bank_q <= '0;
      wcol_q <= '0;
      last_q <= 1'b0;
      idle_q <= 1'b0;
      beat_q <= '0;
      rword_q <= '0;
      wbuf_q <= '0;
      dq_q <= '0;
      oe_q <= 1'b0;
      for (int i = 0; i < 64; i++)
        mr_q[i] <= mr_default(6'(i));
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      ret_q <= ret_d;
      open_q <= open_d;
      row_q <= row_d;
      bank_q <= bank_d;
      wcol_q <= wcol_d;
      last_q <= last_d;
      idle_q <= idle_d;
      beat_q <= beat_d;
      rword_q <= rword_d;
      wbuf_q <= wbuf_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      mr_q <= mr_d;
    end
  end

  // Core array write, one full word per access
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && mem_we)
      mem_q[mem_wa] <= wbuf_d;
  end

  assign lnk.dev_dq_o = dq_q;
  assign lnk.dev_dq_oe = oe_q;
  assign state_o = state_q;
  assign idle_o = idle_q;
  assign open_banks_o = open_q;
endmodule

/* File: dis_pkg.sv */
// Shared constants and types for both ends of the DRAM init sequencer
package dis_pkg;

  // Clock and initialization timing
  localparam int unsigned SYS_CLK_NS        = 25;
  localparam int unsigned RAMP_HOLD_NS      = 200000;
  localparam int unsigned CKE_SETUP_NS      = 10;
  localparam int unsigned POST_RESET_NS     = 2000000;
  localparam int unsigned PRE_ENABLE_CLKS   = 5;
  localparam int unsigned INIT_IDLE_NS      = 2000;
  localparam int unsigned BOOT_CLK_MIN_NS   = 18;
  localparam int unsigned BOOT_CLK_MAX_NS   = 100;
  localparam int unsigned RAMP_HOLD_CYCLES  = (RAMP_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned CKE_SETUP_CYCLES  = (CKE_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned POST_RESET_CYCLES = (POST_RESET_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned INIT_IDLE_CYCLES  = (INIT_IDLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Burst structure
  localparam int unsigned BEATS_PER_WORD = 8;
  localparam int unsigned COL_WORD_LSB   = 4;

  // Commands on the link, qualified by chip select high
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_ACT = 4'h1;
  localparam logic [3:0] CMD_RD  = 4'h2;
  localparam logic [3:0] CMD_WR  = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h4;
  localparam logic [3:0] CMD_MRW = 4'h5;
  localparam logic [3:0] CMD_MRR = 4'h6;
  localparam logic [3:0] CMD_MPC = 4'h7;
  localparam logic [3:0] CMD_SRE = 4'h8;
  localparam logic [3:0] CMD_SRX = 4'h9;

  // Multi-purpose command operands and operand bits
  localparam logic [7:0] MPC_TRAIN_START = 8'h01;
  localparam logic [7:0] MPC_TRAIN_EXIT  = 8'h02;
  localparam int unsigned PRE_ALL_BIT    = 0;

  // Mode register addresses, field positions and reset values
  localparam logic [5:0] MR1_ADDR  = 6'h01;
  localparam logic [5:0] MR2_ADDR  = 6'h02;
  localparam logic [5:0] MR3_ADDR  = 6'h03;
  localparam logic [5:0] MR11_ADDR = 6'h0B;
  localparam logic [5:0] MR12_ADDR = 6'h0C;
  localparam logic [5:0] MR13_ADDR = 6'h0D;
  localparam logic [5:0] MR14_ADDR = 6'h0E;
  localparam int unsigned MR1_BL_BIT      = 0;
  localparam int unsigned MR1_ORDER_BIT   = 3;
  localparam int unsigned MR13_TRAIN_BIT  = 0;
  localparam logic [7:0] MR1_RST  = 8'h00;
  localparam logic [7:0] MR2_RST  = 8'h00;
  localparam logic [7:0] MR3_RST  = 8'h00;
  localparam logic [7:0] MR11_RST = 8'h00;
  localparam logic [7:0] MR12_RST = 8'h4D;
  localparam logic [7:0] MR13_RST = 8'h00;
  localparam logic [7:0] MR14_RST = 8'h4D;

  typedef enum logic [3:0] {
    DS_RESET, DS_INIT, DS_IDLE, DS_ACTIVE, DS_READ, DS_WRITE,
    DS_MRR, DS_MRW, DS_MPC, DS_TRAIN, DS_SREF, DS_PDN
  } dis_dev_state_t;

  typedef enum logic [3:0] {
    CS_HOLD, CS_CKE_SETUP, CS_POST_RESET, CS_CLK_STABLE, CS_IDLE_WAIT,
    CS_READY, CS_WRITE, CS_READ, CS_GAP
  } dis_ctl_state_t;

endpackage

/* File: dis_link_if.sv */
// Pin-level link between memory controller and DRAM device
`timescale 1ns/1ps
interface dis_link_if #(
  parameter int unsigned DQ_W = 16
);
  logic                reset_n;
  logic                cke;
  logic                cs;
  logic [3:0]          cmd;
  logic [2:0]          ba;
  logic [13:0]         addr;
  logic [7:0]          op;
  logic [2*DQ_W-1:0]   ctl_dq_o;
  logic                ctl_dq_oe;
  logic [2*DQ_W-1:0]   dev_dq_o;
  logic                dev_dq_oe;
  logic [2*DQ_W-1:0]   dq;

  // Resolved data bus level; undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);

  modport ctl (
    output reset_n, cke, cs, cmd, ba, addr, op, ctl_dq_o, ctl_dq_oe,
    input  dq, dev_dq_oe
  );
  modport dev (
    input  reset_n, cke, cs, cmd, ba, addr, op, dq,
    output dev_dq_o, dev_dq_oe
  );
endinterface

/* File: dis_dram_ctl.sv */
// Controller end: power-up sequencer and command issue for the DRAM link
`timescale 1ns/1ps
module dis_dram_ctl
  import dis_pkg::*;
#(
  parameter int unsigned DQ_W           = 16,
  parameter int unsigned RAMP_HOLD_CYC  = RAMP_HOLD_CYCLES,
  parameter int unsigned POST_RESET_CYC = POST_RESET_CYCLES
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  dis_link_if.ctl                   lnk,
  input  wire logic                 user_valid,
  input  wire logic [3:0]           user_cmd,
  input  wire logic [2:0]           user_ba,
  input  wire logic [13:0]          user_addr,
  input  wire logic [7:0]           user_op,
  input  wire logic [32*DQ_W-1:0]   user_wdata,
  output logic                      cmd_ready_o,
  output logic                      init_done_o,
  output logic [32*DQ_W-1:0]        rdata_o,
  output logic                      rdata_valid_o
);
  localparam int unsigned BEAT_W = 2 * DQ_W;
  localparam int unsigned BUF_W  = 32 * DQ_W;
  localparam int unsigned CNT_W  = 24;

  if (DQ_W == 0 || RAMP_HOLD_CYC == 0 || POST_RESET_CYC == 0 ||
      RAMP_HOLD_CYC >= (1 << CNT_W) || POST_RESET_CYC >= (1 << CNT_W))
    $error("dis_dram_ctl: unsupported parameter values");
  // Boot clock must lie inside the allowed boot range
  if (SYS_CLK_NS < BOOT_CLK_MIN_NS || SYS_CLK_NS > BOOT_CLK_MAX_NS)
    $error("dis_dram_ctl: clock period outside boot range");

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  logic [BEAT_W:0] pin_s1_q;
  logic [BEAT_W:0] pin_s2_q;
  logic            p_oe;
  logic [BEAT_W-1:0] p_dq;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else if (clk_en)
    begin
      pin_s1_q <= {lnk.dev_dq_oe, lnk.dq};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign {p_oe, p_dq} = pin_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  dis_ctl_state_t    st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              reset_n_q, reset_n_d, cke_q, cke_d, cs_q, cs_d;
  logic [3:0]        cmd_q, cmd_d;
  logic [2:0]        ba_q, ba_d;
  logic [13:0]       addr_q, addr_d;
  logic [7:0]        op_q, op_d;
  logic [BEAT_W-1:0] dq_q, dq_d;
  logic              oe_q, oe_d, bl_q, bl_d, seen_q, seen_d;
  logic [4:0]        beat_q, beat_d;
  logic [BUF_W-1:0]  wdata_q, wdata_d, rbuf_q, rbuf_d, rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d, ready_q, ready_d, done_q, done_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    reset_n_d = reset_n_q;
    cke_d = cke_q;
    cs_d = 1'b0;
    cmd_d = CMD_NOP;
    ba_d = ba_q;
    addr_d = addr_q;
    op_d = op_q;
    dq_d = '0;
    oe_d = 1'b0;
    bl_d = bl_q;
    seen_d = seen_q;
    beat_d = beat_q;
    wdata_d = wdata_q;
    rbuf_d = rbuf_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    ready_d = ready_q;
    done_d = done_q;
    case (st_q)
      // Reset and clock enable are common to every channel, so all ramp together
      CS_HOLD:
        if (cnt_q == '0)
        begin
          st_d = CS_CKE_SETUP;
          cnt_d = CNT_W'(CKE_SETUP_CYCLES - 1);
        end
      CS_CKE_SETUP:
        if (cnt_q == '0)
        begin
          reset_n_d = 1'b1;
          st_d = CS_POST_RESET;
          cnt_d = CNT_W'(POST_RESET_CYC - 1);
        end
      CS_POST_RESET:
        if (cnt_q == '0)
        begin
          st_d = CS_CLK_STABLE;
          cnt_d = CNT_W'(PRE_ENABLE_CLKS - 1);
        end
      CS_CLK_STABLE:
        if (cnt_q == '0)
        begin
          cke_d = 1'b1;
          st_d = CS_IDLE_WAIT;
          cnt_d = CNT_W'(INIT_IDLE_CYCLES - 1);
        end
      CS_IDLE_WAIT:
        if (cnt_q == '0)
        begin
          st_d = CS_READY;
          ready_d = 1'b1;
          done_d = 1'b1;
        end
      CS_READY:
        if (user_valid)
        begin
          cs_d = 1'b1;
          cmd_d = user_cmd;
          ba_d = user_ba;
          addr_d = user_addr;
          op_d = user_op;
          ready_d = 1'b0;
          beat_d = '0;
          seen_d = 1'b0;
          wdata_d = user_wdata;
          if (user_cmd == CMD_MRW && user_addr[5:0] == MR1_ADDR)
            bl_d = user_op[MR1_BL_BIT];
          if (user_cmd == CMD_WR)
            st_d = CS_WRITE;
          else if (user_cmd == CMD_RD || user_cmd == CMD_MRR)
            st_d = CS_READ;
          else
            st_d = CS_GAP;
        end
      CS_WRITE:
      begin
        oe_d = 1'b1;
        dq_d = wdata_q[beat_q*BEAT_W +: BEAT_W];
        beat_d = beat_q + 5'h01;
        if (beat_q == (bl_q ? 5'h0F : 5'h07))
          st_d = CS_GAP;
      end
      // Capture by the device's drive enable, so relaxed boot output timing is tolerated
      CS_READ:
        if (p_oe)
        begin
          seen_d = 1'b1;
          beat_d = beat_q + 5'h01;
          rbuf_d = {p_dq, rbuf_q[BUF_W-1:BEAT_W]};
        end
        else if (seen_q)
        begin
          rdata_d = rbuf_q >> ((6'h10 - {1'b0, beat_q}) * BEAT_W);
          rvalid_d = 1'b1;
          ready_d = 1'b1;
          st_d = CS_READY;
        end
      CS_GAP:
      begin
        ready_d = 1'b1;
        st_d = CS_READY;
      end
      default: st_d = CS_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q <= CS_HOLD;
      cnt_q <= CNT_W'(RAMP_HOLD_CYC - 1);
      reset_n_q <= 1'b0;
      cke_q <= 1'b0;
      cs_q <= 1'b0;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      op_q <= '0;
      dq_q <= '0;
      oe_q <= 1'b0;
      bl_q <= MR1_RST[MR1_BL_BIT];
      seen_q <= 1'b0;
      beat_q <= '0;
      wdata_q <= '0;
      rbuf_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      reset_n_q <= reset_n_d;
      cke_q <= cke_d;
      cs_q <= cs_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      op_q <= op_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      bl_q <= bl_d;
      seen_q <= seen_d;
      beat_q <= beat_d;
      wdata_q <= wdata_d;
      rbuf_q <= rbuf_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      ready_q <= ready_d;
      done_q <= done_d;
    end
  end

  assign lnk.reset_n = reset_n_q;
  assign lnk.cke = cke_q;
  assign lnk.cs = cs_q;
  assign lnk.cmd = cmd_q;
  assign lnk.ba = ba_q;
  assign lnk.addr = addr_q;
  assign lnk.op = op_q;
  assign lnk.ctl_dq_o = dq_q;
  assign lnk.ctl_dq_oe = oe_q;
  assign cmd_ready_o = ready_q;
  assign init_done_o = done_q;
  assign rdata_o = rdata_q;
  assign rdata_valid_o = rvalid_q;
endmodule

/* File: dis_link_asserts.sv */
// Checker of the link between controller and device ends
`timescale 1ns/1ps
module dis_link_asserts
  import dis_pkg::*;
#(
  parameter int unsigned RAMP_HOLD_CYC  = 4,
  parameter int unsigned POST_RESET_CYC = 8
)(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       reset_n,
  input wire logic       cke,
  input wire logic       cs,
  input wire logic [3:0] cmd,
  input wire logic       ctl_dq_oe,
  input wire logic       dev_dq_oe
);
  logic [15:0] low_q;
  logic [15:0] rel_q;
  logic [15:0] on_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles with reset pin low, since reset pin release, and since cke rose
  always_ff @(posedge sys_clk)
  begin
    low_q <= (!rst_n || reset_n) ? 16'h0 : low_q + 16'h1;
    rel_q <= !reset_n ? 16'h0 : (cke ? rel_q : rel_q + 16'h1);
    on_q  <= !cke ? 16'h0 : (on_q == 16'hFFFF ? on_q : on_q + 16'h1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_cke_low_reset: assert property (!reset_n |-> !cke)
    else $error("cke high while reset pin low");
  a_cs_low_cke: assert property ($rose(cke) |-> !cs)
    else $error("chip select high when cke rose");
  a_ramp_hold_len: assert property ($rose(reset_n) |-> low_q >= RAMP_HOLD_CYC)
    else $error("reset pin released too early");
  a_post_reset_wait: assert property ($rose(cke) |-> rel_q >= POST_RESET_CYC)
    else $error("cke raised too soon after reset release");
  a_idle_before_mode: assert property (cs && (cmd == CMD_MRW || cmd == CMD_MRR) |-> on_q >= INIT_IDLE_CYCLES)
    else $error("mode command before idle time");
  a_dq_off_reset: assert property (!reset_n [*5] |-> !dev_dq_oe)
    else $error("device drives data while reset pin low");
  a_wr_burst_beats: assert property (cs && cmd == CMD_WR |=> ctl_dq_oe [*8])
    else $error("write burst shorter than eight beats");
  a_rd_burst_beats: assert property (cs && cmd == CMD_RD |-> ##4 dev_dq_oe [*8])
    else $error("read burst missing or short");
  a_mrr_answer: assert property (cs && cmd == CMD_MRR |-> ##[2:4] dev_dq_oe)
    else $error("mode read not answered");
  c_cke_rise: cover property ($rose(cke));
  c_read: cover property (cs && cmd == CMD_RD);
  c_train: cover property (cs && cmd == CMD_MPC);
endmodule

/* File: dis_dram_init_state_sequencer_bench.sv */
// Self-checking bench joining controller and device ends of the DRAM link
`timescale 1ns/1ps
module dis_dram_init_state_sequencer_bench
  import dis_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           dev_rst_n = 1'b0;
  logic           clk_en = 1'b1;
  logic           user_valid = 1'b0;
  logic [3:0]     user_cmd = CMD_NOP;
  logic [2:0]     user_ba = 3'h0;
  logic [13:0]    user_addr = 14'h0;
  logic [7:0]     user_op = 8'h0;
  logic [511:0]   user_wdata = 512'h0;
  logic [511:0]   rdata_o;
  logic           cmd_ready_o, init_done_o, rdata_valid_o, idle_o;
  logic [7:0]     open_banks_o;
  dis_dev_state_t state_o;
  int             fail_count = 0;
  int             checks_done = 0;
  dis_link_if lnk ();
  dis_dram_ctl #(.RAMP_HOLD_CYC(4), .POST_RESET_CYC(8)) i_dis_dram_ctl (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .lnk(lnk), .user_valid(user_valid), .user_cmd(user_cmd), .user_ba(user_ba),
    .user_addr(user_addr), .user_op(user_op), .user_wdata(user_wdata), .cmd_ready_o(cmd_ready_o),
    .init_done_o(init_done_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o));
  dis_dram_dev i_dis_dram_dev (.sys_clk(sys_clk), .rst_n(dev_rst_n), .clk_en(clk_en), .lnk(lnk),
    .state_o(state_o), .idle_o(idle_o), .open_banks_o(open_banks_o));
  dis_link_asserts #(.RAMP_HOLD_CYC(4), .POST_RESET_CYC(8)) i_dis_link_asserts (.sys_clk(sys_clk),
    .rst_n(rst_n), .reset_n(lnk.reset_n), .cke(lnk.cke), .cs(lnk.cs), .cmd(lnk.cmd),
    .ctl_dq_oe(lnk.ctl_dq_oe), .dev_dq_oe(lnk.dev_dq_oe));
  always #12.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [511:0] e, input logic [511:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task test_done;
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Waits for ready, then holds the request until the taking edge
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic [7:0] o);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (cmd_ready_o !== 1'b1 && n < 5000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("ready", 1, cmd_ready_o);
    @(posedge sys_clk);
    user_valid <= 1'b1;
    user_cmd <= c;
    user_ba <= b;
    user_addr <= a;
    user_op <= o;
    @(posedge sys_clk);
    user_valid <= 1'b0;
  endtask
  task rd_wait(output logic [511:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (rdata_valid_o !== 1'b1 && n < 500)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("rd valid", 1, rdata_valid_o);
    d = rdata_o;
  endtask
  task mr_read(input logic [5:0] a, input logic [7:0] e);
    logic [511:0] d;
    issue(CMD_MRR, 3'h0, {8'h00, a}, 8'h00);
    rd_wait(d);
    chk("mode reg", {504'h0, e}, {504'h0, d[7:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_init_defaults;
    logic [5:0] ad[7];
    logic [7:0] rv[7];
    ad = '{MR1_ADDR, MR2_ADDR, MR3_ADDR, MR11_ADDR, MR12_ADDR, MR13_ADDR, MR14_ADDR};
    rv = '{MR1_RST, MR2_RST, MR3_RST, MR11_RST, MR12_RST, MR13_RST, MR14_RST};
    mr_read(MR1_ADDR, MR1_RST);
    chk("reset pin", 1, lnk.reset_n);
    chk("cke", 1, lnk.cke);
    chk("init done", 1, init_done_o);
    chk("state", DS_IDLE, state_o);
    chk("idle", 1, idle_o);
    foreach (ad[i]) mr_read(ad[i], rv[i]);
  endtask
  task t_burst;
    logic [511:0] d;
    @(posedge sys_clk);
    for (int k = 0; k < 16; k++) user_wdata[k*32 +: 32] <= 32'h0101_0101 * (k + 1);
    issue(CMD_MRW, 3'h0, {8'h00, MR1_ADDR}, 8'h01);
    issue(CMD_ACT, 3'h3, 14'h0005, 8'h00);
    ticks(6);
    chk("open banks", 8'h08, open_banks_o);
    chk("idle", 0, idle_o);
    issue(CMD_WR, 3'h3, 14'h0020, 8'h00);
    issue(CMD_RD, 3'h3, 14'h0020, 8'h00);
    rd_wait(d);
    chk("burst", user_wdata, d);
    // Interleaved order: second word is the partner column word
    issue(CMD_MRW, 3'h0, {8'h00, MR1_ADDR}, 8'h09);
    issue(CMD_RD, 3'h3, 14'h0030, 8'h00);
    rd_wait(d);
    chk("interleave", {user_wdata[255:0], user_wdata[511:256]}, d);
    issue(CMD_PRE, 3'h0, 14'h0, 8'h01);
    ticks(6);
    chk("idle", 1, idle_o);
  endtask
  task t_modes;
    issue(CMD_ACT, 3'h1, 14'h0009, 8'h00);
    issue(CMD_MRW, 3'h0, {8'h00, MR2_ADDR}, 8'h3F);
    ticks(8);
    chk("state", DS_ACTIVE, state_o);
    issue(CMD_PRE, 3'h0, 14'h0, 8'h01);
    issue(CMD_MPC, 3'h0, 14'h0, MPC_TRAIN_START);
    ticks(40);
    chk("state", DS_TRAIN, state_o);
    issue(CMD_MPC, 3'h0, 14'h0, MPC_TRAIN_EXIT);
    ticks(8);
    chk("state", DS_IDLE, state_o);
    issue(CMD_SRE, 3'h0, 14'h0, 8'h00);
    ticks(8);
    chk("state", DS_SREF, state_o);
    issue(CMD_MRW, 3'h0, {8'h00, MR3_ADDR}, 8'h00);
    ticks(8);
    chk("state", DS_SREF, state_o);
    issue(CMD_SRX, 3'h0, 14'h0, 8'h00);
    ticks(8);
    chk("state", DS_IDLE, state_o);
    mr_read(MR2_ADDR, 8'h3F);
  endtask
  // Controller reset only, so the device sees it through the reset pin
  task t_pin_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    ticks(16);
    chk("state", DS_RESET, state_o);
    chk("dq drive", 0, lnk.dev_dq_oe);
    chk("init done", 0, init_done_o);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    mr_read(MR2_ADDR, MR2_RST);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    t_init_defaults;
    t_burst;
    t_modes;
    t_pin_reset;
    test_done;
  end
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    test_done;
  end
endmodule
